// file: hdl/vnr_cfg.svh
// Constants of the video stream framing checker: offsets, fields, resets
`ifndef VNR_CFG_SVH
`define VNR_CFG_SVH

// ==========================================================================
// Register offsets
`define VNR_OFF_CTRL       8'h00
`define VNR_OFF_STATUS     8'h04
`define VNR_OFF_ERROR      8'h08
`define VNR_OFF_MASK       8'h0C
`define VNR_OFF_VERSION    8'h10
`define VNR_OFF_SIZE       8'h20

// ==========================================================================
// Field positions and writable masks
`define VNR_CTRL_BYPASS    2
`define VNR_CTRL_MASK      32'h0000_0004
`define VNR_SIZE_MASK      32'h1FFF_1FFF
`define VNR_SIZE_H_LSB     16
`define VNR_ERR_LINE_SHORT 0
`define VNR_ERR_LINE_LONG  1
`define VNR_ERR_FRM_EARLY  2
`define VNR_ERR_FRM_LATE   3

// ==========================================================================
// Reset values
`define VNR_CTRL_RST       32'h0000_0000
`define VNR_SIZE_RST       32'h01E0_0280
`define VNR_MASK_RST       4'h0

// ==========================================================================
// Timing counts in clock cycles
`define VNR_INIT_CYC       8'h10
`define VNR_FLUSH_CYC      8'h04

// ==========================================================================
// Bus responses
`define VNR_RESP_OKAY      2'h0
`define VNR_RESP_SLVERR    2'h2

`endif

// file: hdl/vnr_pkg.sv
// Types shared by the video stream framing checker
`default_nettype none

package vnr_pkg;
  typedef enum logic [2:0] {
    vnr_st_init  = 3'h1,
    vnr_st_run   = 3'h2,
    vnr_st_flush = 3'h4
  } vnr_state_e;

  typedef logic [3:0] vnr_err_t;
endpackage

`default_nettype wire

// file: hdl/vnr_line_mem.sv
// Pixel memory with registered read data
`default_nettype none

module vnr_line_mem #(
  parameter int W  = 26,
  parameter int AW = 8
) (
  input  wire logic          clock,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output var  logic [W-1:0]  rd_data
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

`default_nettype wire

// file: hdl/vnr_axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time
`default_nettype none
`include "vnr_cfg.svh"

module vnr_axil_slave #(
  parameter int AW = 8
) (
  input  wire logic          clock,
  input  wire logic          reset,
  input  wire logic          clken,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output var  logic          s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output var  logic          s_axi_wready,
  output var  logic [1:0]    s_axi_bresp,
  output var  logic          s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output var  logic          s_axi_arready,
  output var  logic [31:0]   s_axi_rdata,
  output var  logic [1:0]    s_axi_rresp,
  output var  logic          s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output var  logic          wr_req,
  output var  logic [AW-1:0] wr_addr,
  output var  logic [31:0]   wr_data,
  output var  logic [31:0]   wr_mask,
  input  wire logic          wr_err,
  output var  logic          rd_req,
  output var  logic [AW-1:0] rd_addr,
  input  wire logic [31:0]   rd_data,
  input  wire logic          rd_err
);
  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic [AW-1:0] aw_addr_nxt;
  logic [31:0] w_data_nxt, w_mask_nxt, rdata_nxt;
  logic [1:0] bresp_nxt, rresp_nxt;
  logic bvalid_nxt, rvalid_nxt, aw_hs, w_hs;

  // ========================================================================
  // Next state
  always_comb begin
    aw_hs       = clken & s_axi_awvalid & s_axi_awready;
    w_hs        = clken & s_axi_wvalid & s_axi_wready;
    wr_req      = clken & aw_full_r & w_full_r & ~s_axi_bvalid;
    rd_req      = clken & s_axi_arvalid & s_axi_arready;
    rd_addr     = s_axi_araddr;
    aw_full_nxt = (aw_full_r & ~wr_req) | aw_hs;
    w_full_nxt  = (w_full_r & ~wr_req) | w_hs;
    aw_addr_nxt = aw_hs ? s_axi_awaddr : wr_addr;
    w_data_nxt  = w_hs ? s_axi_wdata : wr_data;
    w_mask_nxt  = wr_mask;
    if (w_hs) begin
      for (int i = 0; i < 4; i++) begin
        w_mask_nxt[i*8 +: 8] = {8{s_axi_wstrb[i]}};
      end
    end
    bvalid_nxt = s_axi_bvalid & ~(clken & s_axi_bready);
    bresp_nxt  = s_axi_bresp;
    if (wr_req) begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = wr_err ? `VNR_RESP_SLVERR : `VNR_RESP_OKAY;
    end
    rvalid_nxt = s_axi_rvalid & ~(clken & s_axi_rready);
    rdata_nxt  = s_axi_rdata;
    rresp_nxt  = s_axi_rresp;
    if (rd_req) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = rd_data;
      rresp_nxt  = rd_err ? `VNR_RESP_SLVERR : `VNR_RESP_OKAY;
    end
  end

  // ========================================================================
  // Registers
  always_ff @(posedge clock) begin
    if (reset) begin
      aw_full_r     <= 1'b0;
      w_full_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h0000_0000;
      wr_addr       <= '0;
      wr_data       <= 32'h0000_0000;
      wr_mask       <= 32'h0000_0000;
    end else begin
      aw_full_r     <= aw_full_nxt;
      w_full_r      <= w_full_nxt;
      s_axi_awready <= ~aw_full_nxt;
      s_axi_wready  <= ~w_full_nxt;
      s_axi_arready <= ~rvalid_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_bresp   <= bresp_nxt;
      s_axi_rresp   <= rresp_nxt;
      s_axi_rdata   <= rdata_nxt;
      wr_addr       <= aw_addr_nxt;
      wr_data       <= w_data_nxt;
      wr_mask       <= w_mask_nxt;
    end
  end
endmodule

`default_nettype wire

// file: hdl/vnr_core.sv
// Stream framing checker with register file, line gating and bypass
//
// How it works
// [R1] Short line since last end sets error bit 0
// [R2] Pixel count past width sets error bit 1
// [R3] Frame line count mismatch sets bit 2/3
// [R4] Input ready low during init and flush
// [R5] Output stall fills buffer, then input stalls
// [R6] No output during first two buffered lines unless buffer full or bypass set
// [R7] Surplus line pixels dropped until line end, except in bypass
// [R8] Active-low resets, either holds block in reset
// [R9] Logic advances only while clock enables high
// [R10] Register bus and stream ports both clocked
// [R11] Version register reads fixed release word
// [R12] Bypass bit copies input straight to output; data still passes through the buffer, which a frame mismatch flushes
// [R13] Error flags sticky until cleared or reset
// [R14] Output frame start and line end re-aligned
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none
`include "vnr_cfg.svh"

module vnr_core #(
  parameter int          DATA_W  = 24,
  parameter int          BUF_AW  = 8,
  parameter int          SIZE_W  = 13,
  parameter int          ADDR_W  = 8,
  // Release word, value arbitrary
  parameter logic [31:0] VERSION = 32'h0001_0000
) (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              bus_resetn,
  input  wire logic              stream_resetn,
  input  wire logic              bus_clken,
  input  wire logic              stream_clken,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [DATA_W-1:0] s_axis_tdata,
  input  wire logic              s_axis_tvalid,
  input  wire logic              s_axis_tlast,
  input  wire logic              s_axis_tuser,
  output var  logic              s_axis_tready,
  output var  logic [DATA_W-1:0] m_axis_tdata,
  output var  logic              m_axis_tvalid,
  output var  logic              m_axis_tlast,
  output var  logic              out_frame_start,
  input  wire logic              m_axis_tready,
  output var  logic              irq
);
  localparam int          MW      = DATA_W + 2;
  localparam int          CW      = BUF_AW + 1;
  localparam logic [CW-1:0] DEPTH = CW'(1 << BUF_AW);
  localparam int          FL_MAX  = 8;

  // ========================================================================
  // Reset and bus front end
  logic rst;
  assign rst = reset | ~bus_resetn | ~stream_resetn; // [R8]

  logic              wr_req, wr_err, rd_req, rd_err;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [31:0]       wr_data, wr_mask, rd_data;

  // Both bus and stream sides share clock; no read completes without it
  vnr_axil_slave #(.AW(ADDR_W)) u_bus ( // [R10]
    .clock         (clock),
    .reset         (rst),
    .clken         (bus_clken),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_req        (wr_req),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_mask       (wr_mask),
    .wr_err        (wr_err),
    .rd_req        (rd_req),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  // ========================================================================
  // Register file
  logic [31:0]       ctrl_r, ctrl_nxt, size_r, size_nxt;
  logic [3:0]        mask_r, mask_nxt;
  vnr_pkg::vnr_err_t err_r, err_nxt, err_set;
  logic              irq_nxt, err_rd;

  vnr_pkg::vnr_state_e state_r, state_nxt;
  logic [CW-1:0]       cnt_r, cnt_nxt;
  logic                gate_open, bypass;
  logic [SIZE_W-1:0]   width, height;

  assign bypass = ctrl_r[`VNR_CTRL_BYPASS];
  assign width  = size_r[SIZE_W-1:0];
  assign height = size_r[`VNR_SIZE_H_LSB +: SIZE_W];
  assign err_rd = rd_req & (rd_addr == `VNR_OFF_ERROR);

  always_comb begin
    ctrl_nxt = ctrl_r;
    size_nxt = size_r;
    mask_nxt = mask_r;
    wr_err   = 1'b0;
    if (wr_req) begin
      unique case (wr_addr)
        `VNR_OFF_CTRL: ctrl_nxt = ((ctrl_r & ~wr_mask) | (wr_data & wr_mask))
                                  & `VNR_CTRL_MASK;
        `VNR_OFF_SIZE: size_nxt = ((size_r & ~wr_mask) | (wr_data & wr_mask))
                                  & `VNR_SIZE_MASK;
        `VNR_OFF_MASK: mask_nxt = wr_mask[0] ? wr_data[3:0] : mask_r;
        `VNR_OFF_ERROR, `VNR_OFF_STATUS, `VNR_OFF_VERSION: wr_err = 1'b0;
        default: wr_err = 1'b1;
      endcase
    end
    // A new event wins over the clear done by reading the flags
    err_nxt = (err_r & ~{4{err_rd}}) | err_set; // [R13]
    irq_nxt = |(err_nxt & mask_nxt);
    rd_err  = 1'b0;
    unique case (rd_addr)
      `VNR_OFF_CTRL:    rd_data = ctrl_r;
      `VNR_OFF_SIZE:    rd_data = size_r;
      `VNR_OFF_MASK:    rd_data = {28'h0000000, mask_r};
      `VNR_OFF_ERROR:   rd_data = {28'h0000000, err_r};
      `VNR_OFF_VERSION: rd_data = VERSION; // [R11]
      `VNR_OFF_STATUS:  rd_data = {{(16-CW){1'b0}}, cnt_r, 12'h000,
                                   gate_open, state_r};
      default: begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r <= `VNR_CTRL_RST;
      size_r <= `VNR_SIZE_RST;
      mask_r <= `VNR_MASK_RST;
      err_r  <= 4'h0;
      irq    <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      size_r <= size_nxt;
      mask_r <= mask_nxt;
      err_r  <= err_nxt;
      irq    <= irq_nxt;
    end
  end

  // ========================================================================
  // Stream framing, pixel buffer and output stage
  logic [SIZE_W:0]   pix_r, pix_nxt, line_r, line_nxt;
  logic [7:0]        tmr_r, tmr_nxt;
  logic [1:0]        lines_r, lines_nxt;
  logic              seen_r, seen_nxt, pend_r, pend_nxt, rdy_nxt;
  logic [BUF_AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic              acc, surplus, wr_en, wr_last, rd_go, flush, early, late;
  logic [MW-1:0]     rd_word;
  logic [DATA_W-1:0] mdata_nxt;
  logic              mvalid_nxt, mlast_nxt, muser_nxt;

  always_comb begin
    acc     = stream_clken & s_axis_tvalid & s_axis_tready;
    surplus = pix_r >= {1'b0, width};
    early   = seen_r & (line_r < {1'b0, height});
    late    = seen_r & (line_r > {1'b0, height});
    flush   = acc & s_axis_tuser & (early | late);
    // Bypass keeps the source's own framing and gating off
    wr_en   = acc & (bypass | ~surplus); // [R7] [R12]
    wr_last = s_axis_tlast |
              (~bypass & (pix_r + 1'b1 == {1'b0, width})); // [R14]
    err_set = 4'h0;
    err_set[`VNR_ERR_LINE_SHORT] = acc & s_axis_tlast &
                                   (pix_r + 1'b1 < {1'b0, width}); // [R1]
    err_set[`VNR_ERR_LINE_LONG]  = acc & surplus; // [R2] [R7]
    err_set[`VNR_ERR_FRM_EARLY]  = acc & s_axis_tuser & early; // [R3]
    err_set[`VNR_ERR_FRM_LATE]   = acc & s_axis_tuser & late; // [R3]
    gate_open = bypass | (lines_r == 2'h2) | (cnt_r == DEPTH); // [R6]
    rd_go = stream_clken & (cnt_r != '0) & gate_open & ~pend_r & ~flush &
            (~m_axis_tvalid | m_axis_tready); // [R5] [R6]

    pix_nxt  = pix_r;
    line_nxt = line_r;
    seen_nxt = seen_r;
    if (acc) begin
      if (s_axis_tuser) begin
        line_nxt = '0;
        seen_nxt = 1'b1;
      end
      if (s_axis_tlast) begin
        pix_nxt  = '0;
        line_nxt = (line_nxt == '1) ? line_nxt : line_nxt + 1'b1;
      end else if (pix_r != '1) begin
        pix_nxt = pix_r + 1'b1;
      end
    end

    // A frame mismatch drops what is buffered and restarts line gating
    rp_nxt    = flush ? wp_r : (rd_go ? rp_r + 1'b1 : rp_r);
    wp_nxt    = wr_en ? wp_r + 1'b1 : wp_r;
    cnt_nxt   = flush ? '0 : cnt_r - CW'(rd_go);
    cnt_nxt   = cnt_nxt + CW'(wr_en);
    lines_nxt = flush ? 2'h0 : lines_r;
    if (wr_en & wr_last & (lines_nxt != 2'h2)) begin
      lines_nxt = lines_nxt + 2'h1;
    end
    pend_nxt = stream_clken ? rd_go : pend_r;

    state_nxt = state_r;
    tmr_nxt   = tmr_r;
    if (stream_clken) begin // [R9]
      unique case (state_r)
        vnr_pkg::vnr_st_init: begin
          tmr_nxt = tmr_r + 8'h01;
          if (tmr_r == `VNR_INIT_CYC - 8'h01) begin
            state_nxt = vnr_pkg::vnr_st_run; // [R4]
          end
        end
        vnr_pkg::vnr_st_run: begin
          tmr_nxt = 8'h00;
          if (flush) begin
            state_nxt = vnr_pkg::vnr_st_flush; // [R4]
          end
        end
        vnr_pkg::vnr_st_flush: begin
          tmr_nxt = tmr_r + 8'h01;
          if (tmr_r == `VNR_FLUSH_CYC - 8'h01) begin
            state_nxt = vnr_pkg::vnr_st_run; // [R4]
          end
        end
        default: state_nxt = vnr_pkg::vnr_st_init;
      endcase
    end
    // Ready looks one write ahead, so a full buffer never overflows
    rdy_nxt = (state_nxt == vnr_pkg::vnr_st_run) & (cnt_nxt < DEPTH); // [R4] [R5]

    mvalid_nxt = m_axis_tvalid & ~(stream_clken & m_axis_tready); // [R5]
    mdata_nxt  = m_axis_tdata;
    mlast_nxt  = m_axis_tlast;
    muser_nxt  = out_frame_start;
    if (stream_clken & pend_r) begin
      mvalid_nxt = 1'b1;
      mdata_nxt  = rd_word[DATA_W-1:0];
      mlast_nxt  = rd_word[DATA_W]; // [R14]
      muser_nxt  = rd_word[DATA_W+1]; // [R14]
    end
  end

  vnr_line_mem #(.W(MW), .AW(BUF_AW)) u_mem (
    .clock   (clock),
    .wr_en   (wr_en),
    .wr_addr (wp_r),
    .wr_data ({s_axis_tuser, wr_last, s_axis_tdata}),
    .rd_en   (rd_go),
    .rd_addr (rp_r),
    .rd_data (rd_word)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r         <= vnr_pkg::vnr_st_init;
      tmr_r           <= 8'h00;
      pix_r           <= '0;
      line_r          <= '0;
      seen_r          <= 1'b0;
      lines_r         <= 2'h0;
      wp_r            <= '0;
      rp_r            <= '0;
      cnt_r           <= '0;
      pend_r          <= 1'b0;
      s_axis_tready   <= 1'b0;
      m_axis_tvalid   <= 1'b0;
      m_axis_tdata    <= '0;
      m_axis_tlast    <= 1'b0;
      out_frame_start <= 1'b0;
    end else begin
      state_r         <= state_nxt;
      tmr_r           <= tmr_nxt;
      pix_r           <= pix_nxt;
      line_r          <= line_nxt;
      seen_r          <= seen_nxt;
      lines_r         <= lines_nxt;
      wp_r            <= wp_nxt;
      rp_r            <= rp_nxt;
      cnt_r           <= cnt_nxt;
      pend_r          <= pend_nxt;
      s_axis_tready   <= rdy_nxt;
      m_axis_tvalid   <= mvalid_nxt;
      m_axis_tdata    <= mdata_nxt;
      m_axis_tlast    <= mlast_nxt;
      out_frame_start <= muser_nxt;
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_short;
    acc && s_axis_tlast && (pix_r + 1'b1 < {1'b0, width}) |=> err_r[0];
  endproperty
  a_short: assert property (p_short) else $error("short line not flagged"); // [R1]

  property p_long;
    acc && surplus |=> err_r[1];
  endproperty
  a_long: assert property (p_long) else $error("long line not flagged"); // [R2]

  property p_frame;
    acc && s_axis_tuser && early |=> err_r[2] ##[1:FL_MAX] s_axis_tready;
  endproperty
  a_frame: assert property (p_frame) else $error("early frame mishandled"); // [R3]

  property p_notrun;
    state_r != vnr_pkg::vnr_st_run |-> !s_axis_tready;
  endproperty
  a_notrun: assert property (p_notrun) else $error("ready high outside run"); // [R4]

  property p_full;
    cnt_r == DEPTH |-> !s_axis_tready;
  endproperty
  a_full: assert property (p_full) else $error("ready high while full"); // [R5]

  property p_gate;
    !gate_open |=> !pend_r ##1 !$rose(m_axis_tvalid);
  endproperty
  a_gate: assert property (p_gate) else $error("output before two lines"); // [R6]

  property p_drop;
    acc && surplus && !bypass |-> !wr_en;
  endproperty
  a_drop: assert property (p_drop) else $error("surplus pixel stored"); // [R7]

  property p_version;
    rd_req && rd_addr == `VNR_OFF_VERSION |=> s_axi_rvalid &&
      s_axi_rdata == VERSION;
  endproperty
  a_version: assert property (p_version) else $error("bad version word"); // [R11]

  property p_bypass;
    bypass && acc |-> wr_en && (wr_last == s_axis_tlast);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass altered stream"); // [R12]

  property p_sticky;
    err_r[0] && !err_rd |=> err_r[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost uncleared"); // [R13]

  property p_mark;
    acc && !bypass && (pix_r + 1'b1 == {1'b0, width}) |-> wr_en && wr_last;
  endproperty
  a_mark: assert property (p_mark) else $error("line end not marked"); // [R14]

  property p_hold;
    !stream_clken |=> $stable(state_r) && $stable(cnt_r);
  endproperty
  a_hold: assert property (p_hold) else $error("moved without enable"); // [R9]
endmodule

`default_nettype wire

// file: sim/vnr_sink_model.sv
// Downstream video sink model with a selectable stall pattern
`default_nettype none

module vnr_sink_model (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic slow,
  output var  logic tready
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] cnt_r;

  // ==========================================================
  // Stall pattern
  // Slow mode refuses three cycles in eight, so output must hold
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
    end
  end

  assign tready = !slow || (cnt_r < 3'h5);
endmodule

`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench: register bus, stream framing, bypass, resets
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock = 1'b0, reset = 1'b1, bus_resetn = 1'b1, stream_resetn = 1'b1;
  logic bus_clken = 1'b1, stream_clken = 1'b1, slow = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [23:0] s_axis_tdata = 24'h0, m_axis_tdata;
  logic s_axis_tvalid = 1'b0, s_axis_tlast = 1'b0, s_axis_tuser = 1'b0;
  logic s_axis_tready, m_axis_tvalid, m_axis_tlast, out_frame_start;
  logic m_axis_tready, irq, chk_out = 1'b0;
  logic [31:0] seed = 32'h0000_EE1B;
  int err_total = 0, compares = 0, exp_w = 5;
  logic [1:0] exp_b[$];
  logic [33:0] exp_rd[$];
  logic [25:0] exp_px[$];

  // Four-word buffer, so a slow sink really fills it and stalls input
  vnr_core #(.BUF_AW(2)) dut (.*);
  vnr_sink_model sink (.clock(clock), .reset(reset), .slow(slow),
                       .tready(m_axis_tready));

  always #12.5 clock = ~clock;

  // ==========================================================
  // Shared checks and bus tasks
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic aw_ok, w_ok;
    @(posedge clock);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    exp_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clock);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge clock);
    exp_rd.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // One line of n pixels; the gap cycle keeps valid from double driving
  task automatic send(input int n, input logic sof);
    @(posedge clock);
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      s_axis_tdata <= seed[23:0];
      s_axis_tvalid <= 1'b1;
      s_axis_tlast <= (i == n - 1);
      s_axis_tuser <= sof && (i == 0);
      if (chk_out && i < exp_w)
        exp_px.push_back({sof && (i == 0), (i == n - 1) || (i == exp_w - 1),
                          seed[23:0]});
      do @(posedge clock); while (!s_axis_tready);
    end
    s_axis_tvalid <= 1'b0;
  endtask

  // ==========================================================
  // Result watcher: oldest note against each answer seen
  always @(posedge clock) begin
    if (s_axi_bvalid && s_axi_bready) chk({30'h0, s_axi_bresp},
                                          {30'h0, exp_b.pop_front()});
    if (s_axi_rvalid && s_axi_rready) begin
      chk({30'h0, s_axi_rresp}, {30'h0, exp_rd[0][33:32]});
      chk(s_axi_rdata, exp_rd[0][31:0]);
      exp_rd.delete(0);
    end
    if (chk_out && m_axis_tvalid && m_axis_tready && exp_px.size() > 0)
      chk({6'h00, out_frame_start, m_axis_tlast, m_axis_tdata},
          {6'h00, exp_px.pop_front()});
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    chk({31'h0, s_axis_tready}, 32'h0);
    rd(8'h10, 32'h0001_0000, 2'h0);
    rd(8'h20, 32'h01E0_0280, 2'h0);
    rd(8'h40, 32'h0, 2'h2);
    wr(8'h40, 32'h1, 2'h2);
    wr(8'h20, 32'h0002_0005, 2'h0);
    wr(8'h0C, 32'hF, 2'h0);
    wr(8'h00, 32'h4, 2'h0);
    chk_out <= 1'b1;
    slow <= 1'b1;
    send(5, 1'b1);
    send(5, 1'b0);
    for (int i = 0; i < 200 && exp_px.size() > 0; i++) @(posedge clock);
    chk(exp_px.size(), 32'h0);
    chk_out <= 1'b0;
    wr(8'h00, 32'h0, 2'h0);
    wr(8'h20, 32'h0002_0004, 2'h0);
    rd(8'h08, 32'h0, 2'h0);
    send(3, 1'b0);
    repeat (4) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    rd(8'h08, 32'h1, 2'h0);
    rd(8'h08, 32'h0, 2'h0);
    wr(8'h0C, 32'h0, 2'h0);
    exp_w = 4;
    chk_out <= 1'b1;
    send(7, 1'b0);
    for (int i = 0; i < 200 && exp_px.size() > 0; i++) @(posedge clock);
    chk(exp_px.size(), 32'h0);
    chk_out <= 1'b0;
    repeat (4) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    rd(8'h08, 32'h2, 2'h0);
    send(4, 1'b1);
    rd(8'h08, 32'h8, 2'h0);
    send(4, 1'b1);
    rd(8'h08, 32'h4, 2'h0);
    bus_resetn <= 1'b0;
    stream_clken <= 1'b0;
    repeat (2) @(posedge clock);
    bus_resetn <= 1'b1;
    repeat (2) @(posedge clock);
    chk({31'h0, s_axis_tready}, 32'h0);
    rd(8'h20, 32'h01E0_0280, 2'h0);
    rd(8'h04, 32'h1, 2'h0);
    repeat (20) @(posedge clock);
    chk({31'h0, s_axis_tready}, 32'h0);
    stream_clken <= 1'b1;
    repeat (20) @(posedge clock);
    chk({31'h0, s_axis_tready}, 32'h1);
    end_sim();
  end
endmodule

`default_nettype wire
